//--- rtl/mic_ctrl.sv
// interrupt controller: flags, masks, priority, entry and return sequencing
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module mic_ctrl
  import mic_pkg::*;
#(
  parameter int NPIN = 11
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // register port
  input  wire mic_bus_t         bus,
  output logic      [7:0]       rdata,
  // sources
  input  wire logic             ext_pin,
  input  wire logic [NPIN-1:0]  pins,
  input  wire logic [NPIN-1:0]  alt_fn,
  input  wire mic_timer_ev_t    tev,
  // core sequencer
  input  wire logic             insn_boundary,
  input  wire logic             return_from_handler,
  input  wire logic [PC_W-1:0]  pc_in,
  output logic                  irq_taken,
  output logic                  push_pc,
  output logic      [PC_W-1:0]  push_data,
  output logic                  vector_valid,
  output logic      [PC_W-1:0]  vector_addr,
  output logic                  pop_pc,
  output logic                  busy,
  output logic                  gie
);
  typedef enum logic [2:0] {MIC_IDLE, MIC_ENTRY, MIC_JUMP, MIC_RET, MIC_HOLD} mic_state_t;

  logic rs1_q;
  logic rs_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs1_q <= 1'b0;
      rs_q  <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs_q  <= rs1_q;
    end
  end

  logic [7:0]      pin_mask_q;
  logic [7:0]      timer_mask_q;
  logic [7:0]      ctrl_q;
  logic            ext_flag_q;
  logic            pc_flag_q;
  logic            gie_q;
  logic [3:0]      tflag_q;
  logic            ext_prev_q;
  logic [NPIN-1:0] pins_prev_q;
  mic_state_t      st_q;
  logic [2:0]      cnt_q;
  logic [PC_W-1:0] vec_q;
  logic [2:0]      src_q;
  logic [PC_W-1:0] ret_pc_q;

  wire wr_pm = bus.wr && bus.addr == OFS_PIN_MASK;
  wire wr_pf = bus.wr && bus.addr == OFS_PIN_FLAGS;
  wire wr_tm = bus.wr && bus.addr == OFS_TIMER_MASK;
  wire wr_tf = bus.wr && bus.addr == OFS_TIMER_FLAGS;
  wire wr_cc = bus.wr && bus.addr == OFS_CPU_CTRL;
  wire wr_cs = bus.wr && bus.addr == OFS_CPU_STATUS;

  // external pin sense; pin is observed whatever its direction
  mic_sense_t sense;
  assign sense = mic_sense_t'(ctrl_q[1:0]);
  logic ext_edge;
  always_comb begin
    unique case (sense)
      MIC_LOW:  ext_edge = 1'b0;
      MIC_ANY:  ext_edge = ext_pin ^ ext_prev_q;
      MIC_FALL: ext_edge = ext_prev_q & ~ext_pin;
      MIC_RISE: ext_edge = ~ext_prev_q & ext_pin;
    endcase
  end
  wire ext_level = (sense == MIC_LOW) && !ext_pin;

  // pin change per pin, gated by group enable and alternate function
  logic [NPIN-1:0] pc_hit;
  for (genvar i = 0; i < NPIN; i++) begin : g_pc
    assign pc_hit[i] = (pins[i] ^ pins_prev_q[i]) & ~alt_fn[i]
                     & ((UPPER_PINS[i] & pin_mask_q[BIT_PC_UP])
                      | (LOWER_PINS[i] & pin_mask_q[BIT_PC_LO]));
  end
  wire pc_event = |pc_hit;

  // requests in vector order, lowest vector first
  wire r_ext = (ext_flag_q | ext_level) & pin_mask_q[BIT_EXT];
  wire r_pc  = pc_flag_q & (pin_mask_q[BIT_PC_UP] | pin_mask_q[BIT_PC_LO]);
  wire r_t1a = tflag_q[3] & timer_mask_q[BIT_T1A];
  wire r_t1b = tflag_q[2] & timer_mask_q[BIT_T1B];
  wire r_t1w = tflag_q[1] & timer_mask_q[BIT_T1W];
  wire r_t0w = tflag_q[0] & timer_mask_q[BIT_T0W];
  wire any_req = r_ext | r_pc | r_t1a | r_t1b | r_t1w | r_t0w;

  logic [PC_W-1:0] sel_vec;
  logic [2:0]      sel_src;
  always_comb begin
    sel_vec = VEC_T0W;
    sel_src = 3'd5;
    // fixed priority by vector number
    if (r_ext) begin
      sel_vec = VEC_EXT;
      sel_src = 3'd0;
    end else if (r_pc) begin
      sel_vec = VEC_PCHG;
      sel_src = 3'd1;
    end else if (r_t1a) begin
      sel_vec = VEC_T1A;
      sel_src = 3'd2;
    end else if (r_t1b) begin
      sel_vec = VEC_T1B;
      sel_src = 3'd3;
    end else if (r_t1w) begin
      sel_vec = VEC_T1W;
      sel_src = 3'd4;
    end
  end

  // accept only at an instruction boundary, so multi-cycle ones finish
  wire accept = ce && st_q == MIC_IDLE && gie_q && any_req && insn_boundary && !return_from_handler;
  // vector-time clear strobe, one per taken source
  wire vclr = ce && st_q == MIC_JUMP && cnt_q == 3'd0;

  // sequencer
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      st_q  <= MIC_IDLE;
      cnt_q <= 3'd0;
      vec_q <= '0;
      src_q <= 3'd0;
    end else if (ce) begin
      unique case (st_q)
        MIC_IDLE: begin
          if (return_from_handler) begin
            st_q  <= MIC_RET;
            cnt_q <= RET_CYC - 3'd1;
          end else if (accept) begin
            st_q  <= MIC_ENTRY;
            cnt_q <= ENTRY_CYC - 3'd1;
            vec_q <= sel_vec;
            src_q <= sel_src;
          end
        end
        MIC_ENTRY: begin
          if (cnt_q == 3'd0) begin
            st_q  <= MIC_JUMP;
            cnt_q <= JUMP_CYC - 3'd1;
          end else begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        MIC_JUMP: begin
          if (cnt_q == 3'd0) begin
            st_q <= MIC_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        MIC_RET: begin
          if (cnt_q == 3'd0) begin
            st_q <= MIC_HOLD;
          end else begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        MIC_HOLD: begin
          // one main-program instruction must pass first
          if (insn_boundary) begin
            st_q <= MIC_IDLE;
          end
        end
        // three state bits leave unused codes; fall back to idle
        default: begin
          st_q  <= MIC_IDLE;
          cnt_q <= 3'd0;
        end
      endcase
    end
  end

  // return address frozen at accept so the push sees one value
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      ret_pc_q <= '0;
    end else if (ce) begin
      if (accept) begin
        ret_pc_q <= pc_in;
      end
    end
  end

  // global enable; status register contents other than it are the core's
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      gie_q <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        gie_q <= 1'b0;
      end else if (st_q == MIC_RET && cnt_q == 3'd0) begin
        gie_q <= 1'b1;
      end else if (wr_cs) begin
        gie_q <= bus.wdata[BIT_GIE];
      end
    end
  end

  // mask and control registers
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      pin_mask_q   <= RESET_VAL;
      timer_mask_q <= RESET_VAL;
      ctrl_q       <= RESET_VAL;
    end else if (ce) begin
      if (wr_pm) begin
        pin_mask_q <= bus.wdata & PIN_MASK_RW;
      end
      if (wr_tm) begin
        timer_mask_q <= bus.wdata & TIMER_RW;
      end
      if (wr_cc) begin
        ctrl_q <= bus.wdata & CTRL_RW;
      end
    end
  end

  // history for edge detection
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      ext_prev_q  <= 1'b1;
      pins_prev_q <= '0;
    end else if (ce) begin
      ext_prev_q  <= ext_pin;
      pins_prev_q <= pins;
    end
  end

  // pin flags: set wins over clear; external flag held at zero in level mode
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) begin
      ext_flag_q <= 1'b0;
      pc_flag_q  <= 1'b0;
    end else if (ce) begin
      if (sense == MIC_LOW) begin
        ext_flag_q <= 1'b0;
      end else if (ext_edge) begin
        ext_flag_q <= 1'b1;
      end else if ((vclr && src_q == 3'd0) || (wr_pf && bus.wdata[BIT_EXT])) begin
        ext_flag_q <= 1'b0;
      end
      if (pc_event) begin
        pc_flag_q <= 1'b1;
      end else if ((vclr && src_q == 3'd1) || (wr_pf && bus.wdata[BIT_PCF])) begin
        pc_flag_q <= 1'b0;
      end
    end
  end

  // timer flags in order t1a, t1b, t1w, t0w
  wire [3:0] tev_v = {tev.t1_match_a, tev.t1_match_b, tev.t1_wrap, tev.t0_wrap};
  wire [3:0] tw1 = {bus.wdata[BIT_T1A], bus.wdata[BIT_T1B], bus.wdata[BIT_T1W], bus.wdata[BIT_T0W]};
  for (genvar t = 0; t < 4; t++) begin : g_tf
    always_ff @(posedge clk or negedge rs_q) begin
      if (!rs_q) begin
        tflag_q[t] <= 1'b0;
      end else if (ce) begin
        if (tev_v[t]) begin
          tflag_q[t] <= 1'b1;
        end else if ((vclr && src_q == 3'(5 - t)) || (wr_tf && tw1[t])) begin
          tflag_q[t] <= 1'b0;
        end
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rs_q) begin
    if (!rs_q) rdata <= 8'h00;
    else if (ce) begin
      rdata <= 8'h00;
      if (bus.rd) begin
        unique case (bus.addr)
          OFS_PIN_MASK:    rdata <= pin_mask_q;
          OFS_PIN_FLAGS:   rdata <= {1'b0, ext_flag_q, pc_flag_q, 5'h00};
          OFS_TIMER_MASK:  rdata <= timer_mask_q;
          OFS_TIMER_FLAGS: rdata <= {1'b0, tflag_q[3], tflag_q[2], 2'h0, tflag_q[1], tflag_q[0], 1'b0};
          OFS_CPU_CTRL:    rdata <= ctrl_q;
          OFS_CPU_STATUS:  rdata <= {gie_q, 7'h00};
          default:         rdata <= 8'h00;
        endcase
      end
    end
  end

  // core-facing handshake
  assign irq_taken    = accept;
  assign push_pc      = st_q == MIC_ENTRY;
  assign push_data    = ret_pc_q;
  assign vector_valid = st_q == MIC_JUMP;
  assign vector_addr  = vec_q;
  assign pop_pc       = st_q == MIC_RET;
  assign busy         = st_q != MIC_IDLE;
  assign gie          = gie_q;
endmodule : mic_ctrl

//--- rtl/mic_pkg.sv
// package for the interrupt controller: offsets, fields, reset values, timing
package mic_pkg;
  localparam int PC_W = 10;
  localparam logic [7:0] OFS_TIMER_MASK = 8'h39;
  localparam logic [7:0] OFS_TIMER_FLAGS = 8'h38;
  localparam logic [7:0] OFS_PIN_MASK = 8'h3b;
  localparam logic [7:0] OFS_PIN_FLAGS = 8'h3a;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h35;
  localparam logic [7:0] OFS_CPU_STATUS = 8'h3f;
  localparam int BIT_EXT = 6;
  localparam int BIT_PC_UP = 5;
  localparam int BIT_PC_LO = 4;
  localparam int BIT_PCF = 5;
  localparam int BIT_T1A = 6;
  localparam int BIT_T1B = 5;
  localparam int BIT_T1W = 2;
  localparam int BIT_T0W = 1;
  localparam int BIT_GIE = 7;
  localparam logic [7:0] PIN_MASK_RW = 8'h70;
  localparam logic [7:0] PIN_FLAG_RW = 8'h60;
  localparam logic [7:0] TIMER_RW = 8'h66;
  localparam logic [7:0] CTRL_RW = 8'h03;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [PC_W-1:0] VEC_EXT = 10'h001;
  localparam logic [PC_W-1:0] VEC_PCHG = 10'h002;
  localparam logic [PC_W-1:0] VEC_T1A = 10'h003;
  localparam logic [PC_W-1:0] VEC_T1B = 10'h004;
  localparam logic [PC_W-1:0] VEC_T1W = 10'h005;
  localparam logic [PC_W-1:0] VEC_T0W = 10'h006;
  localparam logic [2:0] ENTRY_CYC = 3'd4;
  localparam logic [2:0] JUMP_CYC = 3'd2;
  localparam logic [2:0] RET_CYC = 3'd4;
  // upper group pins: B7..4 -> 7..4, A7 A6 A3 -> 10..8
  localparam logic [10:0] UPPER_PINS = 11'h7f0;
  localparam logic [10:0] LOWER_PINS = 11'h00f;
  typedef enum logic [1:0] {MIC_LOW, MIC_ANY, MIC_FALL, MIC_RISE} mic_sense_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mic_bus_t;
  typedef struct packed {
    logic t1_match_a;
    logic t1_match_b;
    logic t1_wrap;
    logic t0_wrap;
  } mic_timer_ev_t;
endpackage : mic_pkg

//--- tb/mic_core_model.sv
// core sequencer model: instruction boundaries, program counter, handler return
`timescale 1ns/10ps
module mic_core_model
  import mic_pkg::*;
(
  // clock
  input  wire logic            clk,
  // controller side
  input  wire logic            vector_valid,
  input  wire logic            slow,
  output logic                 insn_boundary,
  output logic                 return_from_handler,
  output logic      [PC_W-1:0] pc_in
);
  logic [1:0]      cnt_q = 2'h0;
  logic [2:0]      hnd_q = 3'h0;
  logic            vv_q  = 1'b0;
  logic            ret_q = 1'b0;
  logic [PC_W-1:0] pc_q  = 10'h100;
  // slow mode: three-cycle instructions, boundary only at the last
  assign insn_boundary = !slow || (cnt_q == 2'h2);
  assign pc_in = pc_q;
  assign return_from_handler = ret_q;
  always @(posedge clk) begin
    cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
    pc_q <= pc_q + 10'h001;
    vv_q <= vector_valid;
    // short handler; status register left to software, never touched here
    if (vv_q && !vector_valid)
      hnd_q <= 3'h3;
    else if (hnd_q != 3'h0)
      hnd_q <= hnd_q - 3'h1;
    ret_q <= (hnd_q == 3'h1);
  end
endmodule : mic_core_model

//--- tb/mic_ctrl_checker.sv
// assertions on the interrupt controller ports
`timescale 1ns/10ps
module mic_ctrl_checker
  import mic_pkg::*;
(
  // clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // core side
  input wire logic            insn_boundary,
  input wire logic            return_from_handler,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic            irq_taken,
  input wire logic            push_pc,
  input wire logic [PC_W-1:0] push_data,
  input wire logic            vector_valid,
  input wire logic [PC_W-1:0] vector_addr,
  input wire logic            pop_pc,
  input wire logic            busy,
  input wire logic            gie
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  entry_timing_a: assert property (irq_taken |=> push_pc [*4] ##1 vector_valid [*2])
    else $error("entry sequence timing wrong");
  gie_drop_a: assert property (irq_taken |=> !gie && busy)
    else $error("global enable kept on entry");
  accept_gate_a: assert property (irq_taken |-> gie && insn_boundary && !return_from_handler)
    else $error("accept outside boundary or enable");
  return_timing_a: assert property (return_from_handler && !busy |=> pop_pc [*4] ##1 (gie && !pop_pc))
    else $error("return sequence timing wrong");
  hold_after_a: assert property ($fell(pop_pc) |-> !irq_taken ##1 (!irq_taken || $past(insn_boundary)))
    else $error("accept right after return");
  vector_range_a: assert property ($rose(vector_valid) |-> vector_addr >= VEC_EXT && vector_addr <= VEC_T0W)
    else $error("vector address out of table");
  push_data_a: assert property (irq_taken |=> push_data == $past(pc_in) ##1 $stable(push_data) [*3])
    else $error("pushed counter differs");
  phase_excl_a: assert property (!(push_pc && pop_pc) && !(vector_valid && push_pc))
    else $error("sequencer phases overlap");
  cover property (irq_taken && insn_boundary);
  cover property ($fell(pop_pc));
  cover property ($rose(vector_valid) && vector_addr == VEC_T0W);
endmodule : mic_ctrl_checker
bind mic_ctrl mic_ctrl_checker mic_ctrl_checker_i (.clk(clk), .rstn(rstn), .insn_boundary(insn_boundary),
  .return_from_handler(return_from_handler), .pc_in(pc_in), .irq_taken(irq_taken), .push_pc(push_pc),
  .push_data(push_data), .vector_valid(vector_valid), .vector_addr(vector_addr), .pop_pc(pop_pc),
  .busy(busy), .gie(gie));

//--- tb/mic_ctrl_bench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
module mic_ctrl_bench;
  import mic_pkg::*;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  mic_bus_t        bus = '0;
  logic            ext_pin = 1'b0;
  logic [10:0]     pins = '0;
  logic [10:0]     alt_fn = '0;
  mic_timer_ev_t   tev = '0;
  logic            slow = 1'b0;
  logic            vv_q = 1'b0;
  logic [7:0]      rdata;
  logic            ib, rfh, taken, pushp, vv, popp, busy, gie;
  logic [PC_W-1:0] pc, pdata, vaddr;
  logic [PC_W-1:0] vq[$];
  logic [7:0]      ofs[7] = '{OFS_TIMER_MASK, OFS_PIN_MASK, OFS_CPU_CTRL, OFS_TIMER_FLAGS, OFS_PIN_FLAGS,
                              OFS_CPU_STATUS, 8'h10};
  logic [7:0]      rwm[7] = '{TIMER_RW, PIN_MASK_RW, CTRL_RW, 8'h00, 8'h00, 8'h80, 8'h00};
  int              fail_count = 0;
  int              checked = 0;
  int              n;
  always #25 clk = ~clk;
  mic_ctrl mic_ctrl_i (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus), .rdata(rdata), .ext_pin(ext_pin),
    .pins(pins), .alt_fn(alt_fn), .tev(tev), .insn_boundary(ib), .return_from_handler(rfh), .pc_in(pc),
    .irq_taken(taken), .push_pc(pushp), .push_data(pdata), .vector_valid(vv), .vector_addr(vaddr),
    .pop_pc(popp), .busy(busy), .gie(gie));
  mic_core_model mic_core_model_i (.clk(clk), .vector_valid(vv), .slow(slow), .insn_boundary(ib),
    .return_from_handler(rfh), .pc_in(pc));
  // log each vector on its second jump cycle, once the address has settled
  always @(posedge clk) begin
    vv_q <= vv;
    if (vv && vv_q) vq.push_back(vaddr);
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(negedge clk);
    chk({2'b00, rdata}, {2'b00, exp});
    @(posedge clk);
  endtask : rdc
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic finish_test();
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    tick(5);
    rstn <= 1'b1;
    tick(3);
    // reset values, writable bits, reserved bits and an unmapped place
    foreach (ofs[i]) begin
      rdc(ofs[i], 8'h00);
      wr(ofs[i], 8'hff);
      rdc(ofs[i], rwm[i]);
      wr(ofs[i], 8'h00);
    end
    tick(1);
    tev <= '1;
    tick(1);
    tev <= '0;
    rdc(OFS_TIMER_FLAGS, TIMER_RW);
    wr(OFS_TIMER_FLAGS, 8'h42);
    rdc(OFS_TIMER_FLAGS, 8'h24);
    tick(1);
    tev <= '1;
    tick(1);
    tev <= '0;
    wr(OFS_TIMER_MASK, TIMER_RW);
    tick(4);
    chk(10'(vq.size()), 10'h000);
    // pending timer flags served in order once enabled, slow instructions
    slow <= 1'b1;
    wr(OFS_CPU_STATUS, 8'h80);
    tick(120);
    chk(10'(vq.size()), 10'h004);
    foreach (vq[i]) chk(vq[i], 10'(i + 3));
    rdc(OFS_TIMER_FLAGS, 8'h00);
    rdc(OFS_CPU_STATUS, 8'h80);
    slow <= 1'b0;
    wr(OFS_TIMER_MASK, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(OFS_CPU_CTRL, 8'(m));
      wr(OFS_PIN_FLAGS, 8'h40);
      ext_pin <= 1'b1;
      tick(3);
      rdc(OFS_PIN_FLAGS, (m != 2) ? 8'h40 : 8'h00);
      wr(OFS_PIN_FLAGS, 8'h40);
      ext_pin <= 1'b0;
      tick(3);
      rdc(OFS_PIN_FLAGS, (m != 3) ? 8'h40 : 8'h00);
    end
    // low level: no flag, requests only while held
    wr(OFS_CPU_CTRL, 8'h00);
    wr(OFS_PIN_FLAGS, 8'h40);
    rdc(OFS_PIN_FLAGS, 8'h00);
    vq.delete();
    wr(OFS_PIN_MASK, 8'h40);
    tick(8);
    ext_pin <= 1'b1;
    tick(20);
    chk(vq[0], VEC_EXT);
    n = vq.size();
    tick(30);
    chk(10'(vq.size()), 10'(n));
    wr(OFS_PIN_MASK, 8'h00);
    wr(OFS_CPU_STATUS, 8'h00);
    vq.delete();
    pins <= 11'h001;
    tick(3);
    rdc(OFS_PIN_FLAGS, 8'h00);
    wr(OFS_PIN_MASK, 8'h10);
    alt_fn <= 11'h002;
    pins <= 11'h003;
    tick(3);
    rdc(OFS_PIN_FLAGS, 8'h00);
    pins <= 11'h002;
    tick(3);
    rdc(OFS_PIN_FLAGS, 8'h20);
    wr(OFS_CPU_STATUS, 8'h80);
    tick(20);
    chk(vq[0], VEC_PCHG);
    rdc(OFS_PIN_FLAGS, 8'h00);
    wr(OFS_PIN_MASK, 8'h20);
    vq.delete();
    pins <= 11'h402;
    tick(20);
    chk(vq[0], VEC_PCHG);
    finish_test();
  end
endmodule : mic_ctrl_bench
